//--- hdl/touch_wheel_command_decoder.sv
// touch-wheel sensor command decoder with its spi slave shifter
// assumes sclk/ss_n/mosi arrive asynchronously; acquisition engine is outside

`timescale 1ns/1ps

module touch_wheel_command_decoder #(
  parameter int          freerun_period = 50000,
  parameter logic        device_class   = 1'b0, // arbitrary value
  parameter int          sig_width      = 12
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // spi link from host
  input  wire logic                 sclk,
  input  wire logic                 ss_n,
  input  wire logic                 mosi,
  output logic                      miso,
  output logic                      data_ready_line,
  // acquisition engine
  input  wire logic [sig_width-1:0] signal_level,
  input  wire logic                 burst_done,
  input  wire logic                 cal_fault,
  input  wire logic [6:0]           position,
  output logic                      burst_start,
  output logic [sig_width-1:0]      reference,
  output logic [7:0]                threshold_level,
  output logic                      touch_detect
);

  ////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [1:0] sclk_s, ss_s, mosi_s;
  logic       sclk_d, ss_d;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s <= 2'h3;
      ss_s   <= 2'h3;
      mosi_s <= 2'h0;
      sclk_d <= 1'b1;
      ss_d   <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      ss_s   <= {ss_s[0], ss_n};
      mosi_s <= {mosi_s[0], mosi};
      sclk_d <= sclk_s[1];
      ss_d   <= ss_s[1];
    end
  end

  logic sclk_rise, sclk_fall, ss_rise, ss_fall;
  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;
  assign ss_rise   = ss_s[1] & ~ss_d;
  assign ss_fall   = ~ss_s[1] & ss_d;

  ////////////////////////////////////////////////////////////////////
  // shifter: sample on rise, change on fall, msb first

  logic [7:0] rx, tx, reply;
  logic [2:0] nbits;
  logic       byte_done;
  logic       framed;

  assign byte_done = ~ss_s[1] & data_ready_line & sclk_rise
                     & (nbits == wheel_pkg::bit_count);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx     <= 8'h00;
      nbits  <= 3'h0;
      tx     <= 8'h00;
      miso   <= 1'b0;
      framed <= 1'b0;
    end else begin
      if (ss_fall) begin
        nbits  <= 3'h0;
        tx     <= reply;
        miso   <= reply[7];
        framed <= 1'b0;
      end else if (!ss_s[1] && data_ready_line) begin
        if (sclk_rise) begin
          rx    <= {rx[6:0], mosi_s[1]};
          nbits <= nbits + 3'h1;
          if (nbits == wheel_pkg::bit_count) framed <= 1'b1;
        end
        // clock idles high, so the first fall must already present bit 7
        if (sclk_fall) begin
          tx   <= {tx[6:0], 1'b0};
          miso <= tx[7];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command decode

  logic [5:0] thr_op;
  logic       want_status, cal_err;
  logic       burst_req;
  logic [3:0] cal_left, drift_cnt, free_cnt;
  logic [7:0] std_resp, stat_resp;

  assign std_resp = touch_detect ? {1'b1, position}
                                 : {1'b0, device_class, 6'h00};
  assign stat_resp = {touch_detect, device_class, 4'h0, cal_err, 1'b0};
  assign reply = want_status ? stat_resp : std_resp;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      thr_op      <= wheel_pkg::thr_reset;
      want_status <= 1'b0;
    end else if (byte_done) begin
      want_status <= (rx[6:0] == wheel_pkg::cmd_status[7:1]) && mosi_s[1] ==
                     wheel_pkg::cmd_status[0];
      if (rx[6:5] == wheel_pkg::cmd_thr_tag) thr_op <= {rx[4:0], mosi_s[1]};
    end
  end

  logic [7:0] last_cmd;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) last_cmd <= 8'h00;
    else if (byte_done) last_cmd <= {rx[6:0], mosi_s[1]};
  end

  ////////////////////////////////////////////////////////////////////
  // bursts, calibration, data ready

  // every select rise starts a burst, with or without clocking (nulls, dummies)
  assign burst_req = ss_rise;
  logic [31:0] free_timer;
  // marks a burst started by the free-run timer; only such bursts feed the fixed drift count
  logic        free_burst;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      burst_start     <= 1'b0;
      cal_left        <= 4'h0;
      cal_err         <= 1'b0;
      data_ready_line <= 1'b1;
      free_timer      <= 32'h0;
      free_burst      <= 1'b0;
    end else begin
      burst_start <= 1'b0;
      if (ss_rise && framed && last_cmd == wheel_pkg::cmd_calibrate) begin
        cal_left        <= wheel_pkg::cal_bursts;
        cal_err         <= 1'b0;
        data_ready_line <= 1'b0;
        burst_start     <= 1'b1;
        free_burst      <= 1'b0;
      end else if (burst_req) begin
        burst_start     <= 1'b1;
        data_ready_line <= 1'b0;
        free_burst      <= 1'b0;
      end else if (burst_done) begin
        if (cal_left > 4'h1) begin
          cal_left    <= cal_left - 4'h1;
          burst_start <= 1'b1;
          if (cal_fault) cal_err <= 1'b1;
        end else begin
          if (cal_left == 4'h1 && cal_fault) cal_err <= 1'b1;
          cal_left        <= 4'h0;
          data_ready_line <= 1'b1;
        end
      end else if (ss_s[1] && ss_d && cal_left == 4'h0) begin
        if (free_timer >= 32'(freerun_period - 1)) begin
          free_timer      <= 32'h0;
          burst_start     <= 1'b1;
          data_ready_line <= 1'b0;
          free_burst      <= 1'b1;
        end else begin
          free_timer <= free_timer + 32'h1;
        end
      end else begin
        // any select activity or calibration restarts the idle count
        free_timer <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // drift and touch detection

  logic [sig_width-1:0] dev;
  logic                 pending;
  assign dev = signal_level - reference;
  assign threshold_level = {thr_op, 2'h0};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      touch_detect <= 1'b0;
      reference    <= sig_width'(wheel_pkg::ref_reset);
      drift_cnt    <= 4'h0;
      free_cnt     <= 4'h0;
      pending      <= 1'b0;
    end else begin
      if (byte_done && {rx[6:0], mosi_s[1]} == wheel_pkg::cmd_drift
          && !touch_detect) pending <= 1'b1;
      if (cal_left == 4'h1 && burst_done) begin
        reference <= signal_level;
        touch_detect <= 1'b0;
      end else if (burst_done && cal_left == 4'h0) begin
        if (!touch_detect && $signed(dev) >= $signed({1'b0, threshold_level}))
          touch_detect <= 1'b1;
        else if (touch_detect && $signed(dev) <
                 $signed({1'b0, threshold_level} - {4'h0, threshold_level[7:3]}))
          touch_detect <= 1'b0;
        if (pending || (free_burst && !touch_detect)) begin
          pending <= 1'b0;
          if (pending ? drift_cnt == wheel_pkg::drift_needed - 4'h1
                      : free_cnt == wheel_pkg::freerun_drift - 4'h1) begin
            if (pending) drift_cnt <= 4'h0;
            else free_cnt <= 4'h0;
            if ($signed(dev) > 0) reference <= reference + sig_width'(1);
            else if ($signed(dev) < 0) reference <= reference - sig_width'(1);
          end else if (pending) drift_cnt <= drift_cnt + 4'h1;
          else free_cnt <= free_cnt + 4'h1;
        end
      end
    end
  end

endmodule

//--- hdl/wheel_pkg.sv
// constants and carriers for the touch-wheel command decoder
// assumes one 250 MHz system clock; link pins are asynchronous to it
package wheel_pkg;
  localparam logic [7:0] cmd_null      = 8'h00;
  localparam logic [7:0] cmd_calibrate = 8'h01;
  localparam logic [7:0] cmd_drift     = 8'h03;
  localparam logic [7:0] cmd_status    = 8'h04;
  localparam logic [1:0] cmd_thr_tag   = 2'h2;
  localparam logic [5:0] thr_reset     = 6'h0a;
  localparam logic [3:0] drift_needed  = 4'ha;
  localparam logic [3:0] freerun_drift = 4'h6;
  localparam logic [3:0] cal_bursts    = 4'ha;
  localparam logic [2:0] bit_count     = 3'h7;
  localparam logic [11:0] ref_reset    = 12'h000;
  // time from a completed burst window; long figures are top parameters
  localparam int clk_mhz = 250;

  typedef struct packed {
    logic       touched;
    logic       cal_error;
    logic [6:0] position;
  } sense_t;
endpackage

//--- testbench/spi_host.sv
// host spi master model, clock idling high
// assumes a 48 ns link clock; the bench calls xfer
`timescale 1ns/1ps
module spi_host (
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic data_ready_line
);
  initial begin
    sclk = 1'b1;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] rsp);
    rsp = 8'h00;
    wait (data_ready_line === 1'b1);
    ss_n = 1'b0;
    #48;
    for (int i = 7; i > 7 - nbits; i--) begin
      sclk = 1'b0;
      mosi = cmd[i];
      #24 sclk = 1'b1;
      rsp[i] = miso;
      #24;
    end
    // a released line must not keep showing the last bit
    mosi = ~mosi;
    #400 ss_n = 1'b1;
    #100;
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench: host model, acquisition stub, integer reference model
// assumes free-run spacing longer than any gap between frames
`timescale 1ns/1ps
module tb;
  logic        clk, rstn, sclk, ss_n, mosi, miso, data_ready_line, cal_fault;
  logic        burst_start, touch_detect;
  logic        burst_done = 1'b0;
  logic [11:0] signal_level, reference;
  logic [7:0]  threshold_level, rsp;
  logic [6:0]  position;
  int          fail_count = 0, tests_run = 0, seed = 32'h9e3a, bcount = 0, edly = 0;
  int          thr = 10, refv = 0, tch = 0, dcnt = 0, calerr = 0, prev4 = 0, fcnt = 0;
  localparam logic cls = 1'b0; // arbitrary class value
  int          sigs[4] = '{100, 36, 34, 100};
  touch_wheel_command_decoder #(.freerun_period(100), .device_class(cls))
    touch_wheel_command_decoder_inst (
    .clk(clk), .rstn(rstn), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .data_ready_line(data_ready_line), .signal_level(signal_level), .burst_done(burst_done),
    .cal_fault(cal_fault), .position(position), .burst_start(burst_start),
    .reference(reference), .threshold_level(threshold_level), .touch_detect(touch_detect));
  spi_host spi_host_inst (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .data_ready_line(data_ready_line));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // acquisition stub: each burst lasts a random 4..19 cycles
  always @(negedge clk) begin
    burst_done <= (edly == 1);
    if (edly > 0) edly--;
    if (burst_start === 1'b1) begin
      bcount++;
      edly = 4 + {$random(seed)} % 16;
    end
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic [7:0] c, input int nb, input int sig);
    logic [7:0] m, e;
    int b0, d, k, nbu;
    @(negedge clk);
    signal_level = sig[11:0];
    e = prev4 ? {tch[0], cls, 6'h00} | {6'h00, calerr[0], 1'b0}
              : (tch ? {1'b1, position} : {1'b0, cls, 6'h00});
    // an empty select pulse shifts nothing back
    m = (nb == 0) ? 8'h00 : prev4 ? 8'hfe : (tch ? 8'hff : 8'hfc);
    nbu = (c == 8'h01) ? 10 : 1;
    b0 = bcount;
    spi_host_inst.xfer(c, nb, rsp);
    for (k = 0; k < 3000 && !(bcount - b0 == nbu && edly == 0 && data_ready_line); k++)
      @(negedge clk);
    if (k >= 3000) fail_count++;
    repeat (4) @(negedge clk);
    if (c == 8'h01) begin
      refv = sig;
      calerr = cal_fault;
    end
    if (c[7:6] == 2'h2) thr = c[5:0];
    if (c == 8'h03 && !tch) dcnt++;
    if (dcnt == 10) begin
      dcnt = 0;
      refv += (sig > refv) ? 1 : -1;
    end
    d = sig - refv;
    tch = tch ? (d >= thr * 4 - thr / 2) : (d >= thr * 4);
    prev4 = (c == 8'h04);
    check("response", rsp & m, e & m);
    check("bursts", bcount - b0, nbu);
    check("threshold", threshold_level, thr * 4);
    check("touch", touch_detect, tch);
    check("reference", reference, refv);
  endtask
  // select held high: the design's own timer paces the bursts
  task automatic free_run(input int sig, input int n);
    int b0, d, k;
    signal_level = sig[11:0];
    repeat (n) begin
      b0 = bcount;
      for (k = 0; k < 3000 && !(bcount != b0 && edly == 0 && data_ready_line); k++)
        @(negedge clk);
      if (k >= 3000) fail_count++;
      repeat (4) @(negedge clk);
      if (!tch) fcnt++;
      if (fcnt == 6) begin
        fcnt = 0;
        refv += (sig > refv) ? 1 : ((sig < refv) ? -1 : 0);
      end
      d = sig - refv;
      tch = tch ? (d >= thr * 4 - thr / 2) : (d >= thr * 4);
    end
    check("free run touch", touch_detect, tch);
    check("free run reference", reference, refv);
  endtask
  initial begin
    rstn = 1'b1;
    signal_level = 12'h000;
    cal_fault = 1'b0;
    position = 7'h00;
    // let every process reach its event control before the reset edge
    #1 rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    position = 7'($random(seed));
    repeat (3) @(negedge clk);
    check("threshold", threshold_level, 32'h28);
    frame(8'h00, 8, 0);
    repeat (4) frame({2'h2, 6'(1 + {$random(seed)} % 63)}, 8, 0);
    frame(8'hbf, 8, 0);
    frame(8'h55, 8, 0);
    frame(8'h8a, 8, 0);
    foreach (sigs[i]) frame(8'h00, 8, sigs[i]);
    repeat (10) frame(8'h03, 8, 100);
    frame(8'h04, 8, 100);
    frame(8'h00, 8, 20);
    repeat (10) frame(8'h03, 8, 20);
    cal_fault = 1'b1;
    frame(8'h01, 8, 50);
    frame(8'h04, 8, 50);
    cal_fault = 1'b0;
    frame(8'h01, 8, 50);
    frame(8'h04, 8, 50);
    frame(8'h00, 0, 50);
    free_run(60, 6);
    complete_run();
  end
  initial begin
    #150000;
    fail_count++;
    complete_run();
  end
endmodule

//--- testbench/wheel_monitor.sv
// port checker for the touch-wheel command decoder
// assumes the handed-over reset values; bound at the foot
`timescale 1ns/1ps
module wheel_monitor #(
  parameter int sig_width = 12
) (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 ss_n,
  input wire logic                 burst_done,
  input wire logic                 burst_start,
  input wire logic                 data_ready_line,
  input wire logic                 touch_detect,
  input wire logic [7:0]           threshold_level,
  input wire logic [sig_width-1:0] reference
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_scale; $changed(threshold_level) |-> !ss_n && threshold_level[1:0] == 2'h0;
  endproperty
  a_scale: assert property (p_scale) else $error("threshold not scaled");
  property p_dflt; $rose(rstn) |-> threshold_level == 8'h28; endproperty
  a_dflt: assert property (p_dflt) else $error("threshold default wrong");
  property p_pulse; burst_start |=> !burst_start; endproperty
  a_pulse: assert property (p_pulse) else $error("burst start too long");
  property p_burst; $rose(ss_n) && data_ready_line |-> ##[1:8] burst_start; endproperty
  a_burst: assert property (p_burst) else $error("no burst after select");
  property p_busy; burst_start |-> ##[0:2] !data_ready_line; endproperty
  a_busy: assert property (p_busy) else $error("ready high in burst");
  property p_touch; $changed(touch_detect) |-> $past(burst_done) || $past(burst_done, 2);
  endproperty
  a_touch: assert property (p_touch) else $error("touch moved off burst");
  property p_ref; $changed(reference) |-> $past(burst_done) || $past(burst_done, 2); endproperty
  a_ref: assert property (p_ref) else $error("reference moved off burst");
  property p_ready; $rose(data_ready_line) |-> $past(burst_done) || $past(burst_done, 2);
  endproperty
  a_ready: assert property (p_ready) else $error("ready rose off burst");
endmodule
bind touch_wheel_command_decoder wheel_monitor #(.sig_width(sig_width)) wheel_monitor_inst (
  .clk(clk), .rstn(rstn), .ss_n(ss_n), .burst_done(burst_done), .burst_start(burst_start),
  .data_ready_line(data_ready_line), .touch_detect(touch_detect),
  .threshold_level(threshold_level), .reference(reference));
